// >>> core/wakeup_pkg.sv
package wakeup_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_STATUS_FIRST = 6'h00;
    localparam logic [5:0] IDX_STATUS_SECOND = 6'h01;
    localparam logic [5:0] IDX_PWR_EN_FIRST = 6'h02;
    localparam logic [5:0] IDX_PWR_EN_SECOND = 6'h03;
    localparam logic [5:0] IDX_WAKEUP_CFG = 6'h04;
    localparam logic [5:0] IDX_LEGACY_ROUTE = 6'h13;
    localparam logic [5:0] IDX_GP_ROUTE = 6'h14;
    localparam int ADDR_LSB = 2;
    // reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    localparam logic [7:0] PWR_EN_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // configuration fields
    localparam int CFG_BANK_LSB = 0;
    localparam int CFG_SWAP_BIT = 2;
    localparam int CFG_S3_PULSE_BIT = 3;
    localparam logic [7:0] CFG_WRITABLE = 8'h0f;
    localparam logic [1:0] BANK_ROUTING = 2'h2;
    // legacy route bits 5 and 7 are reserved
    localparam logic [7:0] LEGACY_ROUTE_WRITABLE = 8'h5f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one clock/data pair of a keyboard or pointer port
    typedef struct packed {
        logic clk;
        logic data;
    } kbm_pair_type;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_type;
endpackage

// >>> core/wakeup_cfg_smi_routing.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R01: the configuration register clears to 00h on power-up and on software reset.
// R02: the configuration register sits at offset 04h outside the banked space, read/write.
// R03: bits 1-0 pick the visible bank; 0 keyboard/mouse, 1 infrared, 2 routing, 3 standby GPIO.
// R04: bit 2 set swaps keyboard clock/data with mouse clock/data; clear means no swap.
// R05: the first routing register is in bank 2 at 13h and resets to zero.
// R06: the second routing register is in bank 2 at 14h and resets to zero.
// R07: a detected legacy event with its route bit set asserts the interrupt, wake enable aside.
// R08: a routed, detected general input event asserts the interrupt, wake enable aside.
// R09: first route: 0 ring 1, 1 ring 2, 2 kbd, 3 mouse, 4 infrared, 6 software; 5, 7 reserved.
// R10: second route bit n routes general input event n; bit 4 is the selected shared-pin event.
// R11: routing acts on detected events after their detectors, not on raw pins.
// R12: event status bits are sticky; bit 4 follows the function selected on the shared pin.
// R13: a detected event with its wake enable set drives the power-wake request low.
// R14: the interrupt output is low while a status bit and its route bit are both set.
// R15: bit 3 of the configuration holds the S3 power-button pulse enable, cleared by default.
module wakeup_cfg_smi_routing (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [7:0] LEGACY_EVENT,
    input wire logic [7:0] GP_INPUT_EVENT,
    input wire logic KEYBOARD_CLOCK_IN,
    input wire logic KEYBOARD_DATA_IN,
    input wire logic POINTER_CLOCK_IN,
    input wire logic POINTER_DATA_IN,
    output logic KBD_CLOCK_TO_CTRL,
    output logic KBD_DATA_TO_CTRL,
    output logic POINTER_CLOCK_TO_CTRL,
    output logic POINTER_DATA_TO_CTRL,
    output logic [1:0] BANK_SELECT,
    output logic S3_POWER_BUTTON_PULSE_EN,
    output logic MGMT_INTERRUPT_N,
    output logic POWER_WAKE_REQUEST_N
);
    // write merge honouring the low byte lane only; the rest is zero
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                         input logic lane, input logic [7:0] writable);
        merge = lane ? ((old & ~writable) | (data & writable)) : old;
    endfunction

    // bank-2 registers only answer while bank 2 is selected
    function automatic logic decode_ok(input logic [5:0] idx, input logic [1:0] bank);
        decode_ok = (idx == wakeup_pkg::IDX_STATUS_FIRST) ||
                    (idx == wakeup_pkg::IDX_STATUS_SECOND) ||
                    (idx == wakeup_pkg::IDX_PWR_EN_FIRST) ||
                    (idx == wakeup_pkg::IDX_PWR_EN_SECOND) ||
                    (idx == wakeup_pkg::IDX_WAKEUP_CFG) ||
                    (bank == wakeup_pkg::BANK_ROUTING &&
                     (idx == wakeup_pkg::IDX_LEGACY_ROUTE || idx == wakeup_pkg::IDX_GP_ROUTE));
    endfunction

    // register file
    logic [7:0] cfg_reg;
    logic [7:0] legacy_route_reg;
    logic [7:0] gp_route_reg;
    logic [7:0] pwr_en_first_reg;
    logic [7:0] pwr_en_second_reg;
    logic [7:0] status_first_reg;
    logic [7:0] status_second_reg;

    // write channel state
    wakeup_pkg::wr_state_type wr_state_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [5:0] aw_idx_reg;
    logic [7:0] w_data_reg;
    logic w_lane_reg;
    logic [1:0] bresp_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;

    // read channel state
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // pin synchronisers and swapped outputs
    wakeup_pkg::kbm_pair_type kbd_meta_reg;
    wakeup_pkg::kbm_pair_type kbd_sync_reg;
    wakeup_pkg::kbm_pair_type ptr_meta_reg;
    wakeup_pkg::kbm_pair_type ptr_sync_reg;
    wakeup_pkg::kbm_pair_type kbd_out_reg;
    wakeup_pkg::kbm_pair_type ptr_out_reg;
    logic irq_n_reg;
    logic pwr_req_n_reg;

    // write channel decode
    wire aw_take = AWVALID && !aw_have_reg && wr_state_reg == wakeup_pkg::WR_IDLE;
    wire w_take = WVALID && !w_have_reg && wr_state_reg == wakeup_pkg::WR_IDLE;
    wire wr_go = aw_have_reg && w_have_reg && wr_state_reg == wakeup_pkg::WR_IDLE;
    wire [1:0] bank = cfg_reg[wakeup_pkg::CFG_BANK_LSB +: 2];
    wire wr_ok = decode_ok(aw_idx_reg, bank);
    wire wr_cfg = wr_go && aw_idx_reg == wakeup_pkg::IDX_WAKEUP_CFG;
    wire wr_legacy = wr_go && wr_ok && aw_idx_reg == wakeup_pkg::IDX_LEGACY_ROUTE;
    wire wr_gp = wr_go && wr_ok && aw_idx_reg == wakeup_pkg::IDX_GP_ROUTE;
    wire wr_en1 = wr_go && aw_idx_reg == wakeup_pkg::IDX_PWR_EN_FIRST;
    wire wr_en2 = wr_go && aw_idx_reg == wakeup_pkg::IDX_PWR_EN_SECOND;
    wire wr_st1 = wr_go && aw_idx_reg == wakeup_pkg::IDX_STATUS_FIRST;
    wire wr_st2 = wr_go && aw_idx_reg == wakeup_pkg::IDX_STATUS_SECOND;
    wire [7:0] clr1 = (wr_st1 && w_lane_reg) ? w_data_reg : 8'h00;
    wire [7:0] clr2 = (wr_st2 && w_lane_reg) ? w_data_reg : 8'h00;

    // read decode
    wire ar_take = ARVALID && arready_reg;
    wire [5:0] ar_idx = ARADDR[7:wakeup_pkg::ADDR_LSB];
    wire rd_ok = decode_ok(ar_idx, bank);
    wire [7:0] rd_byte =
        (ar_idx == wakeup_pkg::IDX_STATUS_FIRST) ? status_first_reg :
        (ar_idx == wakeup_pkg::IDX_STATUS_SECOND) ? status_second_reg :
        (ar_idx == wakeup_pkg::IDX_PWR_EN_FIRST) ? pwr_en_first_reg :
        (ar_idx == wakeup_pkg::IDX_PWR_EN_SECOND) ? pwr_en_second_reg :
        (ar_idx == wakeup_pkg::IDX_WAKEUP_CFG) ? cfg_reg :
        (rd_ok && ar_idx == wakeup_pkg::IDX_LEGACY_ROUTE) ? legacy_route_reg :
        (rd_ok && ar_idx == wakeup_pkg::IDX_GP_ROUTE) ? gp_route_reg : 8'h00;

    // sticky status; an event in the clearing cycle survives the clear
    wire [7:0] st1_next = (status_first_reg & ~clr1) | LEGACY_EVENT; // R12 R11
    wire [7:0] st2_next = (status_second_reg & ~clr2) | GP_INPUT_EVENT; // R12 R10
    // wake enables and routes are independent paths over the same status
    wire irq_any = |(status_first_reg & legacy_route_reg) |
                   |(status_second_reg & gp_route_reg); // R07 R08 R14
    wire wake_any = |(status_first_reg & pwr_en_first_reg) |
                    |(status_second_reg & pwr_en_second_reg); // R13
    wire swap = cfg_reg[wakeup_pkg::CFG_SWAP_BIT];

    // configuration and routing registers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cfg_reg <= wakeup_pkg::CFG_RESET; // R01
            legacy_route_reg <= wakeup_pkg::ROUTE_RESET; // R05
            gp_route_reg <= wakeup_pkg::ROUTE_RESET; // R06
            pwr_en_first_reg <= wakeup_pkg::PWR_EN_RESET;
            pwr_en_second_reg <= wakeup_pkg::PWR_EN_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= merge(cfg_reg, w_data_reg, w_lane_reg,
                                 wakeup_pkg::CFG_WRITABLE); // R02 R15
            end
            if (wr_legacy) begin
                legacy_route_reg <= merge(legacy_route_reg, w_data_reg, w_lane_reg,
                                          wakeup_pkg::LEGACY_ROUTE_WRITABLE); // R09
            end
            if (wr_gp) begin
                gp_route_reg <= merge(gp_route_reg, w_data_reg, w_lane_reg, 8'hff); // R10
            end
            if (wr_en1) begin
                pwr_en_first_reg <= merge(pwr_en_first_reg, w_data_reg, w_lane_reg, 8'hff);
            end
            if (wr_en2) begin
                pwr_en_second_reg <= merge(pwr_en_second_reg, w_data_reg, w_lane_reg, 8'hff);
            end
        end
    end

    // status and interrupt outputs, one cycle behind status
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            status_first_reg <= wakeup_pkg::STATUS_RESET;
            status_second_reg <= wakeup_pkg::STATUS_RESET;
            irq_n_reg <= 1'b1;
            pwr_req_n_reg <= 1'b1;
        end else begin
            status_first_reg <= st1_next;
            status_second_reg <= st2_next;
            irq_n_reg <= !irq_any; // R14
            pwr_req_n_reg <= !wake_any; // R13
        end
    end

    // write handshake: address and data in either order, response after both
    // readies and valid are flops of their own so the bus never sees a decode glitch
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wr_state_reg <= wakeup_pkg::WR_IDLE;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_idx_reg <= 6'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bresp_reg <= wakeup_pkg::RESP_OKAY;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
        end else begin
            unique case (wr_state_reg)
                wakeup_pkg::WR_IDLE: begin
                    if (aw_take) begin
                        aw_have_reg <= 1'b1;
                        aw_idx_reg <= AWADDR[7:wakeup_pkg::ADDR_LSB];
                        awready_reg <= 1'b0;
                    end
                    if (w_take) begin
                        w_have_reg <= 1'b1;
                        w_data_reg <= WDATA[7:0];
                        w_lane_reg <= WSTRB[0];
                        wready_reg <= 1'b0;
                    end
                    if (wr_go) begin
                        aw_have_reg <= 1'b0;
                        w_have_reg <= 1'b0;
                        awready_reg <= 1'b0;
                        wready_reg <= 1'b0;
                        bvalid_reg <= 1'b1;
                        bresp_reg <= wr_ok ? wakeup_pkg::RESP_OKAY : wakeup_pkg::RESP_SLVERR;
                        wr_state_reg <= wakeup_pkg::WR_RESP;
                    end
                end
                wakeup_pkg::WR_RESP: begin
                    if (BREADY) begin
                        wr_state_reg <= wakeup_pkg::WR_IDLE;
                        bvalid_reg <= 1'b0;
                        awready_reg <= 1'b1;
                        wready_reg <= 1'b1;
                    end
                end
                default: begin
                    wr_state_reg <= wakeup_pkg::WR_IDLE;
                    bvalid_reg <= 1'b0;
                    awready_reg <= 1'b1;
                    wready_reg <= 1'b1;
                end
            endcase
        end
    end

    // read handshake: data one cycle after the address is taken
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= wakeup_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rd_byte}; // R03
            rresp_reg <= rd_ok ? wakeup_pkg::RESP_OKAY : wakeup_pkg::RESP_SLVERR;
        end else if (rvalid_reg && RREADY) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    // pins come from another domain, so two flops before the swap mux
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            kbd_meta_reg <= 2'b11;
            kbd_sync_reg <= 2'b11;
            ptr_meta_reg <= 2'b11;
            ptr_sync_reg <= 2'b11;
            kbd_out_reg <= 2'b11;
            ptr_out_reg <= 2'b11;
        end else begin
            kbd_meta_reg <= {KEYBOARD_CLOCK_IN, KEYBOARD_DATA_IN};
            kbd_sync_reg <= kbd_meta_reg;
            ptr_meta_reg <= {POINTER_CLOCK_IN, POINTER_DATA_IN};
            ptr_sync_reg <= ptr_meta_reg;
            // swap after the synchronisers so both ports keep one latency
            kbd_out_reg <= swap ? ptr_sync_reg : kbd_sync_reg; // R04
            ptr_out_reg <= swap ? kbd_sync_reg : ptr_sync_reg; // R04
        end
    end

    // outputs straight from flops
    assign AWREADY = awready_reg;
    assign WREADY = wready_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign ARREADY = arready_reg;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;
    assign KBD_CLOCK_TO_CTRL = kbd_out_reg.clk;
    assign KBD_DATA_TO_CTRL = kbd_out_reg.data;
    assign POINTER_CLOCK_TO_CTRL = ptr_out_reg.clk;
    assign POINTER_DATA_TO_CTRL = ptr_out_reg.data;
    assign BANK_SELECT = bank; // R03
    assign S3_POWER_BUTTON_PULSE_EN = cfg_reg[wakeup_pkg::CFG_S3_PULSE_BIT]; // R15
    assign MGMT_INTERRUPT_N = irq_n_reg;
    assign POWER_WAKE_REQUEST_N = pwr_req_n_reg;
endmodule // wakeup_cfg_smi_routing
`default_nettype wire

// >>> verif/wakeup_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks; route and status regs are internal, so causes are bus writes or events
module wakeup_monitor (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [7:0] LEGACY_EVENT,
    input wire logic [7:0] GP_INPUT_EVENT,
    input wire logic KEYBOARD_CLOCK_IN,
    input wire logic POINTER_CLOCK_IN,
    input wire logic KBD_CLOCK_TO_CTRL,
    input wire logic [1:0] BANK_SELECT,
    input wire logic S3_POWER_BUTTON_PULSE_EN,
    input wire logic MGMT_INTERRUPT_N,
    input wire logic POWER_WAKE_REQUEST_N
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // answers stand until taken; config pins move only after a write
    a_reset_clear: assert property ($fell(RST) |->
        BANK_SELECT == 2'h0 && !S3_POWER_BUTTON_PULSE_EN)
        else $error("config outputs not clear after reset");
    a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    a_rdata_byte: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_bank_cause: assert property ($changed(BANK_SELECT) |-> BVALID || $past(BVALID))
        else $error("bank select moved without a write");
    a_pulse_cause: assert property ($changed(S3_POWER_BUTTON_PULSE_EN) |->
        BVALID || $past(BVALID))
        else $error("pulse enable moved without a write");
    // a swap only picks the source; the delay from pin to output stays three cycles
    a_pin_source: assert property (KBD_CLOCK_TO_CTRL == $past(KEYBOARD_CLOCK_IN, 3) ||
        KBD_CLOCK_TO_CTRL == $past(POINTER_CLOCK_IN, 3))
        else $error("keyboard clock output from no pin");
    a_irq_fall: assert property ($fell(MGMT_INTERRUPT_N) |->
        $past(|LEGACY_EVENT, 2) || $past(|GP_INPUT_EVENT, 2) || $past(BVALID))
        else $error("interrupt asserted without cause");
    a_irq_rise: assert property ($rose(MGMT_INTERRUPT_N) |-> $past(BVALID))
        else $error("interrupt released without a write");
    a_wake_fall: assert property ($fell(POWER_WAKE_REQUEST_N) |->
        $past(|LEGACY_EVENT, 2) || $past(|GP_INPUT_EVENT, 2) || $past(BVALID))
        else $error("wake request without cause");
endmodule // wakeup_monitor
bind wakeup_cfg_smi_routing wakeup_monitor i_wakeup_monitor (.CORE_CLK, .RST, .BVALID, .BREADY,
    .BRESP, .RVALID, .RREADY, .RDATA, .LEGACY_EVENT, .GP_INPUT_EVENT, .KEYBOARD_CLOCK_IN,
    .POINTER_CLOCK_IN, .KBD_CLOCK_TO_CTRL, .BANK_SELECT, .S3_POWER_BUTTON_PULSE_EN,
    .MGMT_INTERRUPT_N, .POWER_WAKE_REQUEST_N);
`default_nettype wire

// >>> verif/host_irq_input.sv
`timescale 1ns/1ps
`default_nettype none
// chipset side: a level input; counting falls exposes stray re-triggers
module host_irq_input (
    input wire logic clk,
    input wire logic rst,
    input wire logic mgmt_interrupt_n,
    output logic [7:0] request_count
);
    logic prev_reg;
    // count each new low level on the active-low input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= 1'b1;
            request_count <= 8'h00;
        end else begin
            prev_reg <= mgmt_interrupt_n;
            if (prev_reg && !mgmt_interrupt_n) request_count <= request_count + 8'h01;
        end
    end
endmodule // host_irq_input
`default_nettype wire

// >>> verif/test_wakeup_cfg_smi_routing.sv
`timescale 1ns/1ps
`default_nettype none
module test_wakeup_cfg_smi_routing;
    logic CORE_CLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [7:0] AWADDR = 0, ARADDR = 0, LEGACY_EVENT = 0, GP_INPUT_EVENT = 0, irq_count;
    logic [31:0] WDATA = 0, RDATA, q;
    logic [3:0] WSTRB = 0, pins = 4'hf;
    wire [3:0] to_ctrl;
    logic [1:0] BRESP, RRESP, BANK_SELECT, r;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, S3_POWER_BUTTON_PULSE_EN;
    logic MGMT_INTERRUPT_N, POWER_WAKE_REQUEST_N;
    int errors = 0, tests_run = 0;
    wakeup_cfg_smi_routing i_wakeup_cfg_smi_routing (.CORE_CLK, .RST, .AWADDR, .AWVALID,
        .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
        .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .LEGACY_EVENT, .GP_INPUT_EVENT,
        .KEYBOARD_CLOCK_IN(pins[3]), .KEYBOARD_DATA_IN(pins[2]), .POINTER_CLOCK_IN(pins[1]),
        .POINTER_DATA_IN(pins[0]), .KBD_CLOCK_TO_CTRL(to_ctrl[3]), .KBD_DATA_TO_CTRL(to_ctrl[2]),
        .POINTER_CLOCK_TO_CTRL(to_ctrl[1]), .POINTER_DATA_TO_CTRL(to_ctrl[0]), .BANK_SELECT,
        .S3_POWER_BUTTON_PULSE_EN, .MGMT_INTERRUPT_N, .POWER_WAKE_REQUEST_N);
    host_irq_input i_host_irq_input (.clk(CORE_CLK), .rst(RST),
        .mgmt_interrupt_n(MGMT_INTERRUPT_N), .request_count(irq_count));
    initial begin
        forever #2 CORE_CLK = ~CORE_CLK;
    end
    task close_out;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // one transfer; readiness is sampled at the falling edge so the rising edge is race free
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        logic pa, pd, ta, td, done;
        @(posedge CORE_CLK);
        if (w) begin
            AWADDR <= a;
            WDATA <= {24'h0, d};
            WSTRB <= 4'h1;
            AWVALID <= 1'b1;
            WVALID <= 1'b1;
            BREADY <= 1'b1;
        end else begin
            ARADDR <= a;
            ARVALID <= 1'b1;
            RREADY <= 1'b1;
        end
        pa = 1;
        pd = w;
        done = 0;
        n = 0;
        while (!done) begin
            @(negedge CORE_CLK);
            n++;
            if (n > 40) begin
                errors++;
                $display("unexpected at %0t: bus answer missing", $time);
                close_out();
            end
            ta = pa && ((w ? AWREADY : ARREADY) === 1'b1);
            td = pd && (WREADY === 1'b1);
            done = (w ? BVALID : RVALID) === 1'b1;
            q = RDATA;
            r = w ? BRESP : RRESP;
            @(posedge CORE_CLK);
            if (ta) begin
                pa = 0;
                AWVALID <= 1'b0;
                ARVALID <= 1'b0;
            end
            if (td) begin
                pd = 0;
                WVALID <= 1'b0;
            end
            if (done) begin
                BREADY <= 1'b0;
                RREADY <= 1'b0;
            end
        end
    endtask
    task wr(input logic [7:0] a, d, input logic [1:0] e = wakeup_pkg::RESP_OKAY);
        bus(1'b1, a, d);
        chk(r, e);
    endtask
    task rd(input logic [7:0] a, d, input logic [1:0] e = wakeup_pkg::RESP_OKAY);
        bus(1'b0, a, 8'h0);
        chk(q, d);
        chk(r, e);
    endtask
    task settle(input int n);
        repeat (n) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask
    task pulse(input logic [7:0] l, g);
        @(posedge CORE_CLK);
        LEGACY_EVENT <= l;
        GP_INPUT_EVENT <= g;
        @(posedge CORE_CLK);
        LEGACY_EVENT <= 8'h0;
        GP_INPUT_EVENT <= 8'h0;
    endtask
    task t_reset;
        rd(8'h10, 8'h00);
        rd(8'h4c, 8'h00, wakeup_pkg::RESP_SLVERR);
        chk(BANK_SELECT, 2'h0);
        $display("test reset done");
    endtask
    task t_config;
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h0f);
        chk({BANK_SELECT, S3_POWER_BUTTON_PULSE_EN}, 3'h7);
        @(posedge CORE_CLK);
        pins <= 4'b0110;
        settle(5);
        chk(to_ctrl, 4'b1001);
        wr(8'h10, 8'h01);
        wr(8'h4c, 8'h55, wakeup_pkg::RESP_SLVERR);
        rd(8'h50, 8'h00, wakeup_pkg::RESP_SLVERR);
        wr(8'h10, 8'h02);
        settle(5);
        chk(to_ctrl, 4'b0110);
        chk({BANK_SELECT, S3_POWER_BUTTON_PULSE_EN}, 3'h4);
        $display("test config done");
    endtask
    task t_route;
        rd(8'h4c, 8'h00);
        rd(8'h50, 8'h00);
        wr(8'h4c, 8'hff);
        rd(8'h4c, 8'h5f);
        wr(8'h50, 8'hff);
        rd(8'h50, 8'hff);
        rd(8'h20, 8'h00, wakeup_pkg::RESP_SLVERR);
        wr(8'h4c, 8'h04);
        wr(8'h50, 8'h10);
        $display("test route done");
    endtask
    // wake enables stay zero until the routed events have raised the interrupt, so the interrupt must not depend on them
    task t_events;
        pulse(8'h08, 8'h00);
        settle(4);
        chk(MGMT_INTERRUPT_N, 1'b1);
        pulse(8'h04, 8'h00);
        settle(4);
        chk({MGMT_INTERRUPT_N, POWER_WAKE_REQUEST_N}, 2'b01);
        rd(8'h00, 8'h0c);
        wr(8'h00, 8'hff);
        settle(2);
        chk(MGMT_INTERRUPT_N, 1'b1);
        pulse(8'h00, 8'h10);
        settle(4);
        chk(MGMT_INTERRUPT_N, 1'b0);
        wr(8'h0c, 8'h10);
        settle(2);
        chk(POWER_WAKE_REQUEST_N, 1'b0);
        wr(8'h04, 8'hff);
        settle(2);
        chk({MGMT_INTERRUPT_N, POWER_WAKE_REQUEST_N, irq_count}, 10'h302);
        $display("test events done");
    endtask
    task t_mid_reset;
        wr(8'h10, 8'h0d);
        @(posedge CORE_CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'b0;
        rd(8'h10, 8'h00);
        chk({BANK_SELECT, S3_POWER_BUTTON_PULSE_EN}, 3'h0);
        $display("test mid reset done");
    endtask
    initial begin
        repeat (4) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_reset();
        t_config();
        t_route();
        t_events();
        t_mid_reset();
        close_out();
    end
endmodule // test_wakeup_cfg_smi_routing
`default_nettype wire
